// File: design/dor_pkg.sv
package dor_pkg;

  // Register geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // Register offsets
  localparam logic [7:0] OFS_CHAN_A_OFFSET = 8'h08;
  localparam logic [7:0] OFS_FIFO_B_OFFSET = 8'h09;
  localparam logic [7:0] OFS_SCALE_POWER   = 8'h0A;

  // Reset values
  localparam logic [15:0] RST_CHAN_A_OFFSET = 16'h4000;
  localparam logic [15:0] RST_FIFO_B_OFFSET = 16'h8000;
  localparam logic [15:0] RST_SCALE_POWER   = 16'hF080;

  // Writable bits; the rest hold their reset value
  localparam logic [15:0] WMASK_CHAN_A_OFFSET = 16'h1FFF;
  localparam logic [15:0] WMASK_FIFO_B_OFFSET = 16'hFFFF;
  localparam logic [15:0] WMASK_SCALE_POWER   = 16'hF9E0;

  // Field positions
  localparam int unsigned OFFSET_LSB     = 0;
  localparam int unsigned OFFSET_W       = 13;
  localparam int unsigned FIFO_START_LSB = 13;
  localparam int unsigned FIFO_START_W   = 3;
  localparam int unsigned COARSE_LSB     = 12;
  localparam int unsigned COARSE_W       = 4;
  localparam int unsigned FUSE_SLEEP_BIT = 11;
  localparam int unsigned TSENSE_BIT     = 8;
  localparam int unsigned CLKRECV_BIT    = 7;
  localparam int unsigned SLEEP_A_BIT    = 6;
  localparam int unsigned SLEEP_B_BIT    = 5;

  // Full-scale step count is coarse value plus this
  localparam logic [4:0] COARSE_STEP_ADD = 5'h01;

  // Answer to an unmapped read
  localparam logic [15:0] RDATA_UNMAPPED = 16'h0000;

  // Whole block state
  typedef struct packed {
    logic [15:0] chan_a_offset;
    logic [15:0] fifo_b_offset;
    logic [15:0] scale_power;
    logic [15:0] rdata;
    logic        offset_sync;
    logic [2:0]  fifo_rd_ptr;
    logic [4:0]  fs_steps;
  } dor_state_t;

endpackage : dor_pkg

// File: design/dor_config_regs.sv
`timescale 1ns/1ps

// How it works
// - Channel A offset, 13 bits in converter LSBs, drives the A sample path.
// - Channel B offset, 13 bits in converter LSBs, drives the B sample path.
// - Each write to the channel B offset register pulses offset sync.
// - FIFO sync loads read pointer with 3-bit start field, reset 100.
// - Coarse 4-bit scale sets full-scale as value plus one; reset all ones.
// - Fuse sleep bit high sleeps the fuse bank; low wakes it.
// - Temperature sensor sleep bit sleeps the sensor; resets to zero.
// - Clock receiver is on while its enable is set; enable resets to one.
// - Channel A sleep bit puts channel A to sleep.
// - Channel B sleep bit puts channel B to sleep.
// - Fuse single-channel indication never sleeps channel B by itself.
module dor_config_regs
  import dor_pkg::*;
(
  input  wire logic                i_clock,
  input  wire logic                i_rst_b,
  input  wire logic [ADDR_W-1:0]   i_reg_addr,
  input  wire logic                i_reg_wr,
  input  wire logic [DATA_W-1:0]   i_reg_wdata,
  input  wire logic                i_reg_rd,
  input  wire logic                i_fifo_sync,
  output logic      [DATA_W-1:0]   o_reg_rdata,
  output logic      [OFFSET_W-1:0] o_offset_a,
  output logic      [OFFSET_W-1:0] o_offset_b,
  output logic                     o_offset_sync,
  output logic      [2:0]          o_fifo_rd_ptr,
  output logic      [COARSE_W-1:0] o_coarse_scale,
  output logic      [4:0]          o_fs_steps,
  output logic                     o_fuse_sleep,
  output logic                     o_tsense_sleep,
  output logic                     o_clkrecv_en,
  output logic                     o_sleep_a,
  output logic                     o_sleep_b
);

  dor_state_t state_q;
  dor_state_t state_d;

  // Port timing, as the serial decoder in front of this bank sees it:
  //   write at edge N: fields and the sync pulse show from edge N+1
  //   read at edge N: answer shows from N+1 and holds until the next read
  //   read and write to one offset in one cycle return the old word
  //   fifo sync at edge N: pointer holds the stored start from N+1
  //   reset: one edge with i_rst_b low restores every word
  // The step count costs five flops so every output comes from a flop

  // Limits: the serial framing lives outside; this bank sees only strobes.
  //   No fuse single-channel input exists here, so channel B sleep
  //   follows its own bit alone and software must set it.
  //   Unmapped offsets swallow writes and read back zero.

  // Write strobes per register, decoded once
  logic wr_chan_a;
  logic wr_fifo_b;
  logic wr_scale;

  // Read strobes per register, decoded once
  logic rd_chan_a;
  logic rd_fifo_b;
  logic rd_scale;

  // Merge write data under a mask so reserved bits keep their reset value
  function automatic logic [DATA_W-1:0] merge_write(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [DATA_W-1:0] wmask
  );
    merge_write = (old_val & ~wmask) | (new_val & wmask);
  endfunction : merge_write

  // One strobe aimed at one offset; shared by the read and write decodes
  function automatic logic hits(
    input logic              strobe,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs
  );
    hits = strobe && (addr == ofs);
  endfunction : hits

  // Start position held in the upper field of the B offset word
  function automatic logic [FIFO_START_W-1:0] start_of(
    input logic [DATA_W-1:0] word
  );
    start_of = word[FIFO_START_LSB +: FIFO_START_W];
  endfunction : start_of

  // Coarse field of the scale word
  function automatic logic [COARSE_W-1:0] coarse_of(
    input logic [DATA_W-1:0] word
  );
    coarse_of = word[COARSE_LSB +: COARSE_W];
  endfunction : coarse_of

  // Step count is coarse plus one; the extra bit keeps 16 from wrapping
  function automatic logic [COARSE_W:0] steps_of(
    input logic [COARSE_W-1:0] coarse
  );
    steps_of = {1'b0, coarse} + COARSE_STEP_ADD;
  endfunction : steps_of

  // Complete reset image of the bank
  function automatic dor_state_t reset_image();
    dor_state_t img;
    img               = '0;
    img.chan_a_offset = RST_CHAN_A_OFFSET;
    img.fifo_b_offset = RST_FIFO_B_OFFSET;
    img.scale_power   = RST_SCALE_POWER;
    img.rdata         = RDATA_UNMAPPED;
    img.offset_sync   = 1'b0;
    // Derived fields follow the reset words, no separate constants
    img.fifo_rd_ptr   = start_of(RST_FIFO_B_OFFSET);
    img.fs_steps      = steps_of(coarse_of(RST_SCALE_POWER));
    reset_image = img;
  endfunction : reset_image

  // Address decodes; an unmapped offset matches none of them
  assign wr_chan_a = hits(i_reg_wr, i_reg_addr, OFS_CHAN_A_OFFSET);
  assign wr_fifo_b = hits(i_reg_wr, i_reg_addr, OFS_FIFO_B_OFFSET);
  assign wr_scale  = hits(i_reg_wr, i_reg_addr, OFS_SCALE_POWER);
  assign rd_chan_a = hits(i_reg_rd, i_reg_addr, OFS_CHAN_A_OFFSET);
  assign rd_fifo_b = hits(i_reg_rd, i_reg_addr, OFS_FIFO_B_OFFSET);
  assign rd_scale  = hits(i_reg_rd, i_reg_addr, OFS_SCALE_POWER);

  // Next-state logic for the whole bank
  always_comb
  begin
    state_d = state_q;
    // Sync is a single-cycle pulse; it falls unless re-armed below
    state_d.offset_sync = 1'b0;
    // Writes land in one cycle; reads see the value before this write
    if (wr_chan_a)
    begin
      state_d.chan_a_offset = merge_write(state_q.chan_a_offset,
        i_reg_wdata, WMASK_CHAN_A_OFFSET);
    end

    if (wr_fifo_b)
    begin
      state_d.fifo_b_offset = merge_write(state_q.fifo_b_offset,
        i_reg_wdata, WMASK_FIFO_B_OFFSET);
      // Every write pulses, even with unchanged data
      state_d.offset_sync = 1'b1;
    end

    if (wr_scale)
    begin
      state_d.scale_power = merge_write(state_q.scale_power,
        i_reg_wdata, WMASK_SCALE_POWER);
    end
    // Registered read answer, zero for unmapped offsets
    if (i_reg_rd)
    begin
      // Unmapped offsets fall through to zero
      state_d.rdata = RDATA_UNMAPPED;
      if (rd_chan_a)
      begin
        state_d.rdata = state_q.chan_a_offset;
      end
      if (rd_fifo_b)
      begin
        state_d.rdata = state_q.fifo_b_offset;
      end
      if (rd_scale)
      begin
        state_d.rdata = state_q.scale_power;
      end
    end
    // Pointer takes the start field as stored before a same-cycle write
    if (i_fifo_sync)
    begin
      state_d.fifo_rd_ptr = start_of(state_q.fifo_b_offset);
    end
    // Uses the next scale word so steps move with the coarse output
    state_d.fs_steps = steps_of(coarse_of(state_d.scale_power));
  end

  // State register, synchronous active-low reset
  always_ff @(posedge i_clock)
  begin
    // One edge with the pin low is enough to restore the bank
    if (!i_rst_b)
    begin
      state_q <= reset_image();
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Read port; holds the last answer until the next read
  assign o_reg_rdata    = state_q.rdata;

  // Offsets and their sync pulse toward the offset correction block
  assign o_offset_a     = state_q.chan_a_offset[OFFSET_LSB +: OFFSET_W];
  assign o_offset_b     = state_q.fifo_b_offset[OFFSET_LSB +: OFFSET_W];
  assign o_offset_sync  = state_q.offset_sync;

  // FIFO read pointer, loaded only by a sync event
  assign o_fifo_rd_ptr  = state_q.fifo_rd_ptr;

  // Full-scale current, raw field and step count
  assign o_coarse_scale = coarse_of(state_q.scale_power);
  assign o_fs_steps     = state_q.fs_steps;

  // Sleep controls for the fuse bank and sensor, active high
  assign o_fuse_sleep   = state_q.scale_power[FUSE_SLEEP_BIT];
  assign o_tsense_sleep = state_q.scale_power[TSENSE_BIT];
  // Enable resets to one, so the part is clocked straight out of reset
  assign o_clkrecv_en   = state_q.scale_power[CLKRECV_BIT];
  // Channel A sleep, its own bit only
  assign o_sleep_a      = state_q.scale_power[SLEEP_A_BIT];
  // Only the bit decides; a fused single-channel part still needs it set
  assign o_sleep_b      = state_q.scale_power[SLEEP_B_BIT];

endmodule : dor_config_regs

// File: tb/dor_config_regs_monitor.sv
`timescale 1ns/1ps
// Checks field outputs against the write strobes that set them
module dor_config_regs_monitor (
  input wire logic        i_clock,
  input wire logic        i_rst_b,
  input wire logic [7:0]  i_reg_addr,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  input wire logic        i_fifo_sync,
  input wire logic [15:0] o_reg_rdata,
  input wire logic [12:0] o_offset_a,
  input wire logic [12:0] o_offset_b,
  input wire logic        o_offset_sync,
  input wire logic [2:0]  o_fifo_rd_ptr,
  input wire logic [3:0]  o_coarse_scale,
  input wire logic [4:0]  o_fs_steps,
  input wire logic        o_fuse_sleep,
  input wire logic        o_tsense_sleep,
  input wire logic        o_clkrecv_en,
  input wire logic        o_sleep_a,
  input wire logic        o_sleep_b
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // Write to the B offset, then a lone pointer sync
  sequence s_wr_b; i_reg_wr && i_reg_addr == 8'h09; endsequence
  sequence s_sync_alone; i_fifo_sync && !i_reg_wr; endsequence
  AST_OFS_A: assert property (i_reg_wr && i_reg_addr == 8'h08 |=>
    o_offset_a == $past(i_reg_wdata[12:0])) else $error("offset a");
  AST_OFS_B: assert property (s_wr_b |=>
    o_offset_b == $past(i_reg_wdata[12:0])) else $error("offset b");
  AST_SYNC: assert property (s_wr_b |=> o_offset_sync)
    else $error("sync missing");
  AST_SYNC_CAUSE: assert property (o_offset_sync |-> $past(i_reg_wr)
    && $past(i_reg_addr) == 8'h09) else $error("stray sync");
  AST_PTR_LOAD: assert property (s_wr_b ##1 s_sync_alone |=>
    o_fifo_rd_ptr == $past(i_reg_wdata[15:13], 2)) else $error("ptr");
  AST_PTR_HOLD: assert property (!i_fifo_sync |=>
    $stable(o_fifo_rd_ptr)) else $error("ptr moved");
  AST_STEPS: assert property (
    o_fs_steps == {1'b0, o_coarse_scale} + 5'h01) else $error("steps");
  AST_PWR: assert property (
    i_reg_wr && i_reg_addr == 8'h0A |=>
    {o_coarse_scale, o_fuse_sleep, o_tsense_sleep, o_clkrecv_en, o_sleep_a,
     o_sleep_b} == $past({i_reg_wdata[15:11], i_reg_wdata[8:5]}))
    else $error("power bits");
  AST_B_ONLY: assert property (!(i_reg_wr && i_reg_addr == 8'h0A) |=>
    $stable(o_sleep_b)) else $error("sleep b moved");
  AST_RD_A: assert property (
    i_reg_rd && !i_reg_wr && i_reg_addr == 8'h08
    |=> o_reg_rdata == {3'b010, o_offset_a}) else $error("read a");
endmodule : dor_config_regs_monitor

// File: tb/dor_config_regs_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module dor_config_regs_tb;
  logic        i_clock = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [7:0]  i_reg_addr = 8'h00;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic        i_fifo_sync = 1'b0;
  logic [15:0] o_reg_rdata;
  logic [12:0] o_offset_a, o_offset_b;
  logic [2:0]  o_fifo_rd_ptr;
  logic [3:0]  o_coarse_scale;
  logic [4:0]  o_fs_steps;
  logic o_offset_sync, o_fuse_sleep, o_tsense_sleep, o_clkrecv_en, o_sleep_a;
  logic o_sleep_b;
  int error_cnt = 0, total_checks = 0;
  dor_config_regs uut (.*);
  // 40 MHz clock
  initial forever #12.5 i_clock = ~i_clock;
  // Strobes rise and fall on falling edges, clear of the sampling edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clock) {i_reg_addr, i_reg_wdata, i_reg_wr} = {a, d, 1'b1};
    @(negedge i_clock) i_reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge i_clock) {i_reg_addr, i_reg_rd} = {a, 1'b1};
    @(negedge i_clock) i_reg_rd = 1'b0;
    `CHK("rdata", e, o_reg_rdata)
  endtask : rd
  // Reset values, and an unmapped place that stays empty
  task automatic t_reset;
    rd(8'h08, 16'h4000);
    rd(8'h09, 16'h8000);
    rd(8'h0A, 16'hF080);
    `CHK("ptr", 3'h4, o_fifo_rd_ptr)
    `CHK("steps", 5'h10, o_fs_steps)
    `CHK("clkrecv", 1'b1, o_clkrecv_en)
    wr(8'h0B, 16'hFFFF);
    rd(8'h0B, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  // Offsets, auto sync pulse and pointer load from the start field
  task automatic t_offsets;
    wr(8'h08, 16'hFFFF);
    rd(8'h08, 16'h5FFF);
    `CHK("offset_a", 13'h1FFF, o_offset_a)
    wr(8'h09, 16'hA123);
    `CHK("sync", 1'b1, o_offset_sync)
    `CHK("ptr early", 3'h4, o_fifo_rd_ptr)
    i_fifo_sync = 1'b1;
    @(negedge i_clock) i_fifo_sync = 1'b0;
    `CHK("sync end", 1'b0, o_offset_sync)
    `CHK("offset_b", 13'h0123, o_offset_b)
    `CHK("ptr", 3'h5, o_fifo_rd_ptr)
    $display("test offsets done");
  endtask : t_offsets
  // One control bit at a time, reserved bits written high must read zero
  task automatic t_power;
    int b[5] = '{11, 8, 7, 6, 5};
    logic [4:0] ctl;
    for (int k = 0; k < 5; k++)
    begin
      wr(8'h0A, (16'h0001 << b[k]) | 16'h061F | (16'(k) << 12));
      ctl = {o_fuse_sleep, o_tsense_sleep, o_clkrecv_en, o_sleep_a,
        o_sleep_b};
      `CHK("ctl", 5'h10 >> k, ctl)
      `CHK("coarse", 4'(k), o_coarse_scale)
      `CHK("steps", 5'(k + 1), o_fs_steps)
      rd(8'h0A, (16'h0001 << b[k]) | (16'(k) << 12));
    end
    // Single-channel setup: software itself sets the B sleep bit
    wr(8'h0A, 16'hF0A0);
    `CHK("sleep_b", 1'b1, o_sleep_b)
    `CHK("sleep_a", 1'b0, o_sleep_a)
    `CHK("coarse", 4'hF, o_coarse_scale)
    `CHK("steps", 5'h10, o_fs_steps)
    $display("test power done");
  endtask : t_power
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (6) @(posedge i_clock);
    @(negedge i_clock) i_rst_b = 1'b1;
    t_reset();
    t_offsets();
    t_power();
    final_report();
  end
endmodule : dor_config_regs_tb
bind dor_config_regs dor_config_regs_monitor u_mon (.*);
